// file: pkg/crm_pkg.sv
package crm_pkg;

    // condition word field positions
    localparam int unsigned CSW_STOP_BIT  = 15;
    localparam int unsigned CSW_MV_BIT    = 14;
    localparam int unsigned CSW_H_BIT     = 13;
    localparam int unsigned CSW_EV_BIT    = 12;
    localparam int unsigned CSW_N_BIT     = 11;
    localparam int unsigned CSW_Z_BIT     = 10;
    localparam int unsigned CSW_V_BIT     = 9;
    localparam int unsigned CSW_C_BIT     = 8;
    localparam int unsigned CSW_IP_LSB    = 5;
    localparam int unsigned CSW_SM_BIT    = 4;
    localparam int unsigned CSW_PK_LSB    = 0;

    // mac accumulator layout
    localparam int unsigned MAC_SIGN_BIT  = 35;
    localparam int unsigned MAC_EXT_BIT   = 31;

    // saturation limits of the mac accumulator
    localparam logic [35:0] MAC_SAT_POS   = 36'h7FFFFFFFF;
    localparam logic [35:0] MAC_SAT_NEG   = 36'h800000000;

    // stack step sizes
    localparam logic [19:0] STEP_WORD     = 20'h00002;
    localparam logic [19:0] STEP_BYTE     = 20'h00001;

    // register select codes for the write port
    typedef enum logic [3:0] {
        CRM_SEL_ACC_HI = 4'h0,
        CRM_SEL_ACC_LO = 4'h1,
        CRM_SEL_DBL    = 4'h2,
        CRM_SEL_EXTRA  = 4'h3,
        CRM_SEL_IDX_X  = 4'h4,
        CRM_SEL_IDX_Y  = 4'h5,
        CRM_SEL_IDX_Z  = 4'h6,
        CRM_SEL_SP     = 4'h7,
        CRM_SEL_PC     = 4'h8,
        CRM_SEL_CSW    = 4'h9,
        CRM_SEL_KREG   = 4'hA,
        CRM_SEL_SK     = 4'hB,
        CRM_SEL_HR     = 4'hC,
        CRM_SEL_IR     = 4'hD,
        CRM_SEL_MSK    = 4'hE,
        CRM_SEL_NONE   = 4'hF
    } crm_sel_e;

    // address space marking
    typedef enum logic [0:0] {
        CRM_SPACE_DATA = 1'b0,
        CRM_SPACE_PROG = 1'b1
    } crm_space_e;

    // address source for the address generator
    typedef enum logic [2:0] {
        CRM_ASRC_PC  = 3'h0,
        CRM_ASRC_X   = 3'h1,
        CRM_ASRC_Y   = 3'h2,
        CRM_ASRC_Z   = 3'h3,
        CRM_ASRC_SP  = 3'h4,
        CRM_ASRC_EXT = 3'h5,
        CRM_ASRC_VEC = 3'h6
    } crm_asrc_e;

    // flag update from the execution logic
    typedef struct packed {
        logic       upd_nzv;   // update n, z, v
        logic       upd_c;     // update carry
        logic       upd_h;     // update half carry
        logic       n_in;
        logic       z_in;
        logic       v_in;
        logic       c_in;
        logic       h_in;
    } crm_flags_s;

    // reset vector payload for the third index pair
    typedef struct packed {
        logic        load;
        logic [3:0]  bank;
        logic [15:0] ptr;
    } crm_rstvec_s;

endpackage

// file: logic/crm_core.sv
// Overview of operation
// - two byte accumulators, double view, extra accumulator
// - three 16-bit index registers with banks
// - reset vector loads third index and bank
// - stack decrements on push, increments on pull
// - stack steps by word, bytes allowed
// - 20-bit program counter, fetch bit zero forced
// - fixed condition word bit layout
// - stop bit clear halts clock on stop
// - overflow into bit 35 sets mac flag
// - overflow into bit 31 sets extension flag
// - nibble carry in decimal add sets half
// - negative set from most significant bit
// - zero set when all bits clear
// - signed overflow sets overflow flag
// - carry from arithmetic, chained through shifts
// - three-bit priority mask gates interrupts
// - saturated mac reads clamp by old sign
// - six bank fields, four in bank register
// - address is bank over 16-bit byte address
// - mac multiplier, multiplicand, accumulator, masks
// - fetches and reset vector are program space
module crm_core (
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    // register write port from execution logic
    input  wire logic                 wr_en_i,
    input  wire crm_pkg::crm_sel_e    wr_sel_i,
    input  wire logic [15:0]          wr_data_i,
    input  wire logic [3:0]           wr_bank_i,
    input  wire crm_pkg::crm_flags_s  flags_i,
    input  wire logic                 reset_vec_valid_i,
    input  wire crm_pkg::crm_rstvec_s rst_vec_i,
    // program counter and stack control
    input  wire logic                 pc_load_i,
    input  wire logic [19:0]          pc_next_i,
    input  wire logic                 push_i,
    input  wire logic                 pull_i,
    input  wire logic                 byte_op_i,
    // address generation
    input  wire crm_pkg::crm_asrc_e   asrc_i,
    input  wire logic [15:0]          ext_addr_i,
    input  wire logic [15:0]          vec_addr_i,
    input  wire logic                 vec_is_reset_i,
    // mac interface
    input  wire logic                 mac_wr_i,
    input  wire logic [35:0]          mac_sum_i,
    input  wire logic                 mac_ovf35_i,
    input  wire logic                 mac_ovf31_i,
    input  wire logic                 flag_clr_mv_i,
    input  wire logic                 flag_clr_ev_i,
    // stop and interrupt
    input  wire logic                 stop_exec_i,
    input  wire logic [2:0]           irq_level_i,
    // register bus
    input  wire logic [3:0]           bus_addr_i,
    input  wire logic [15:0]          bus_wdata_i,
    input  wire logic                 bus_we_i,
    input  wire logic                 bus_re_i,
    output logic [15:0]               bus_rdata_o,
    // outputs
    output logic [19:0]               addr_o,
    output logic                      space_prog_o,
    output logic [15:0]               dbl_acc_o,
    output logic [15:0]               extra_acc_o,
    output logic [15:0]               csw_o,
    output logic [35:0]               mac_read_o,
    output logic                      irq_accept_o,
    output logic                      clk_halt_o
);

    // programmer visible state
    logic [7:0]  acc_hi_q, acc_lo_q;
    logic [15:0] extra_q;
    logic [15:0] idx_x_q, idx_y_q, idx_z_q, sp_q, pc_q;
    logic [3:0]  bk_x_q, bk_y_q, bk_z_q, bk_e_q, bk_s_q, bk_p_q;
    logic        stop_q, mv_q, h_q, ev_q, n_q, z_q, v_q, c_q, sm_q;
    logic [2:0]  ip_q;
    logic [15:0] hr_q, ir_q;
    logic [35:0] am_q;
    logic        am_sign_q;
    logic [7:0]  modulo_mask_first_q, modulo_mask_second_q;
    logic        halt_q;
    logic [15:0] rdata_q;

    // write decode
    wire         wr_hi   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_ACC_HI);
    wire         wr_lo   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_ACC_LO);
    wire         wr_dbl  = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_DBL);
    wire         wr_e    = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_EXTRA);
    wire         wr_x    = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_IDX_X);
    wire         wr_y    = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_IDX_Y);
    wire         wr_z    = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_IDX_Z);
    wire         wr_sp   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_SP);
    wire         wr_csw  = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_CSW);
    wire         wr_k    = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_KREG);
    wire         wr_sk   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_SK);
    wire         wr_hr   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_HR);
    wire         wr_ir   = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_IR);
    wire         wr_msk  = wr_en_i && (wr_sel_i == crm_pkg::CRM_SEL_MSK);

    // stack step: word normally, byte when asked
    wire [19:0]  sp_step = byte_op_i ? crm_pkg::STEP_BYTE
                                     : crm_pkg::STEP_WORD;
    wire [19:0]  sp_full = {bk_s_q, sp_q};
    wire [19:0]  sp_push = sp_full - sp_step;
    wire [19:0]  sp_pull = sp_full + sp_step;
    wire [19:0]  sp_next = push_i ? sp_push : (pull_i ? sp_pull : sp_full);

    // condition word assembly
    assign csw_o = {stop_q, mv_q, h_q, ev_q, n_q, z_q, v_q, c_q,
                    ip_q, sm_q, bk_p_q};
    wire [15:0]  kreg = {bk_e_q, bk_x_q, bk_y_q, bk_z_q};

    // accumulator views
    assign dbl_acc_o   = {acc_hi_q, acc_lo_q};
    assign extra_acc_o = extra_q;

    // mac read with saturation
    wire         mac_ovf_any = mv_q || ev_q;
    wire         sat_on      = sm_q && mac_ovf_any;
    wire [35:0]  sat_val     = am_sign_q ? crm_pkg::MAC_SAT_NEG
                                         : crm_pkg::MAC_SAT_POS;
    assign mac_read_o = sat_on ? sat_val : am_q;

    // interrupt masking: request must exceed mask, level 7 always
    assign irq_accept_o = (irq_level_i > ip_q) ||
                          (irq_level_i == 3'h7);

    // address generation
    logic [19:0] addr_d;
    always_comb begin
        case (asrc_i)
            crm_pkg::CRM_ASRC_PC: addr_d = {bk_p_q, pc_q[15:1], 1'b0};
            crm_pkg::CRM_ASRC_X:   addr_d = {bk_x_q, idx_x_q};
            crm_pkg::CRM_ASRC_Y:   addr_d = {bk_y_q, idx_y_q};
            crm_pkg::CRM_ASRC_Z:   addr_d = {bk_z_q, idx_z_q};
            crm_pkg::CRM_ASRC_SP:  addr_d = sp_full;
            crm_pkg::CRM_ASRC_EXT: addr_d = {bk_e_q, ext_addr_i};
            crm_pkg::CRM_ASRC_VEC: addr_d = {4'h0, vec_addr_i};
            default:               addr_d = 20'h00000;
        endcase
    end
    assign addr_o = addr_d;
    assign space_prog_o = (asrc_i == crm_pkg::CRM_ASRC_PC) ||
                          ((asrc_i == crm_pkg::CRM_ASRC_VEC)
                           && vec_is_reset_i);

    // stop control
    assign clk_halt_o = halt_q;

    // register bus read mux
    logic [15:0] rd_mux;
    always_comb begin
        case (bus_addr_i)
            4'h0:    rd_mux = {acc_hi_q, acc_lo_q};
            4'h1:    rd_mux = extra_q;
            4'h2:    rd_mux = idx_x_q;
            4'h3:    rd_mux = idx_y_q;
            4'h4:    rd_mux = idx_z_q;
            4'h5:    rd_mux = sp_q;
            4'h6:    rd_mux = pc_q;
            4'h7:    rd_mux = csw_o;
            4'h8:    rd_mux = kreg;
            4'h9:    rd_mux = {12'h000, bk_s_q};
            4'hA:    rd_mux = hr_q;
            4'hB:    rd_mux = ir_q;
            4'hC:    rd_mux = mac_read_o[35:20];
            4'hD:    rd_mux = mac_read_o[15:0];
            4'hE:    rd_mux = {modulo_mask_first_q, modulo_mask_second_q};
            default: rd_mux = 16'h0000;
        endcase
    end
    assign bus_rdata_o = rdata_q;

    // read data register, one cycle after strobe
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= bus_re_i ? rd_mux : 16'h0000;
        end
    end

    // accumulators, index and mac operand registers; undefined at reset
    always_ff @(posedge clk_sys_i) begin
        if (wr_hi || wr_dbl) begin
            acc_hi_q <= wr_dbl ? wr_data_i[15:8] : wr_data_i[7:0];
        end
        if (wr_lo || wr_dbl) begin
            acc_lo_q <= wr_data_i[7:0];
        end
        if (wr_e) extra_q <= wr_data_i;
        if (wr_x) idx_x_q <= wr_data_i;
        if (wr_y) idx_y_q <= wr_data_i;
        if (wr_hr) hr_q <= wr_data_i;
        if (wr_ir) ir_q <= wr_data_i;
        if (wr_msk) begin
            modulo_mask_first_q <= wr_data_i[15:8];
            modulo_mask_second_q <= wr_data_i[7:0];
        end
        if (mac_wr_i) begin
            am_q      <= mac_sum_i;
            am_sign_q <= am_q[crm_pkg::MAC_SIGN_BIT];
        end
    end

    // bank fields, stack pointer and program counter
    always_ff @(posedge clk_sys_i) begin
        if (reset_vec_valid_i && rst_vec_i.load) begin
            idx_z_q <= rst_vec_i.ptr;
            bk_z_q  <= rst_vec_i.bank;
        end else if (wr_z) begin
            idx_z_q <= wr_data_i;
            bk_z_q  <= wr_bank_i;
        end else if (wr_k) begin
            bk_z_q  <= wr_data_i[3:0];
        end
        if (wr_k) begin
            bk_e_q <= wr_data_i[15:12];
            bk_x_q <= wr_data_i[11:8];
            bk_y_q <= wr_data_i[7:4];
        end else begin
            if (wr_x) bk_x_q <= wr_bank_i;
            if (wr_y) bk_y_q <= wr_bank_i;
        end
        if (wr_sp) begin
            {bk_s_q, sp_q} <= {wr_bank_i, wr_data_i};
        end else if (wr_sk) begin
            bk_s_q <= wr_data_i[3:0];
        end else begin
            {bk_s_q, sp_q} <= sp_next;
        end
        if (pc_load_i) begin
            {bk_p_q, pc_q} <= pc_next_i;
        end else if (wr_csw) begin
            bk_p_q <= wr_data_i[3:0];
        end
    end

    // condition flags; hardware set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            stop_q <= 1'b0;
            ip_q   <= 3'h7;
            sm_q   <= 1'b0;
            mv_q   <= 1'b0;
            ev_q   <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            if (wr_csw) begin
                stop_q <= wr_data_i[crm_pkg::CSW_STOP_BIT];
                ip_q   <= wr_data_i[crm_pkg::CSW_IP_LSB +: 3];
                sm_q   <= wr_data_i[crm_pkg::CSW_SM_BIT];
            end
            if (mac_wr_i && mac_ovf35_i) begin
                mv_q <= 1'b1;
            end else if (flag_clr_mv_i) begin
                mv_q <= 1'b0;
            end else if (wr_csw) begin
                mv_q <= wr_data_i[crm_pkg::CSW_MV_BIT];
            end
            if (mac_wr_i && mac_ovf31_i) begin
                ev_q <= 1'b1;
            end else if (flag_clr_ev_i) begin
                ev_q <= 1'b0;
            end else if (wr_csw) begin
                ev_q <= wr_data_i[crm_pkg::CSW_EV_BIT];
            end
            halt_q <= halt_q || (stop_exec_i && !stop_q);
        end
    end

    // arithmetic flags supplied by execution logic
    always_ff @(posedge clk_sys_i) begin
        if (flags_i.upd_nzv) begin
            n_q <= flags_i.n_in;
            z_q <= flags_i.z_in;
            v_q <= flags_i.v_in;
        end else if (wr_csw) begin
            n_q <= wr_data_i[crm_pkg::CSW_N_BIT];
            z_q <= wr_data_i[crm_pkg::CSW_Z_BIT];
            v_q <= wr_data_i[crm_pkg::CSW_V_BIT];
        end
        if (flags_i.upd_c) begin
            c_q <= flags_i.c_in;
        end else if (wr_csw) begin
            c_q <= wr_data_i[crm_pkg::CSW_C_BIT];
        end
        if (flags_i.upd_h) begin
            h_q <= flags_i.h_in;
        end else if (wr_csw) begin
            h_q <= wr_data_i[crm_pkg::CSW_H_BIT];
        end
    end

endmodule

// file: tb/crm_exec_model.sv
module crm_exec_model (
    input  wire logic                clk_sys_i,
    input  wire logic                req_i,
    input  wire logic                add_i,
    input  wire crm_pkg::crm_sel_e   sel_i,
    input  wire logic [15:0]         data_i,
    input  wire logic [15:0]         opb_i,
    input  wire logic [3:0]          bank_i,
    output crm_pkg::crm_sel_e        wr_sel_o,
    output logic                     wr_en_o,
    output logic [15:0]              wr_data_o,
    output logic [3:0]               wr_bank_o,
    output crm_pkg::crm_flags_s      flags_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] sum;
    logic        ovf;
    // an add writes its sum to the selected register with its flags
    assign sum = {1'b0, data_i} + {1'b0, opb_i};
    assign ovf = (data_i[15] == opb_i[15]) && (sum[15] != data_i[15]);
    // one write-port cycle per request, one edge after it
    always_ff @(posedge clk_sys_i) begin
        wr_en_o   <= req_i;
        wr_sel_o  <= sel_i;
        wr_data_o <= add_i ? sum[15:0] : data_i;
        wr_bank_o <= bank_i;
        flags_o   <= {{3{req_i & add_i}}, sum[15],
                      sum[15:0] == 16'h0, ovf, sum[16],
                      sum[4] ^ data_i[4] ^ opb_i[4]};
    end
endmodule

// file: tb/crm_core_props.sv
module crm_core_props (
    input wire logic               clk_sys_i,
    input wire logic               resetn_i,
    input wire logic               wr_en_i,
    input wire crm_pkg::crm_sel_e  wr_sel_i,
    input wire logic [15:0]        wr_data_i,
    input wire crm_pkg::crm_asrc_e asrc_i,
    input wire logic [15:0]        vec_addr_i,
    input wire logic               vec_is_reset_i,
    input wire logic               mac_wr_i,
    input wire logic               mac_ovf35_i,
    input wire logic               mac_ovf31_i,
    input wire logic               stop_exec_i,
    input wire logic [2:0]         irq_level_i,
    input wire logic [19:0]        addr_o,
    input wire logic               space_prog_o,
    input wire logic [15:0]        dbl_acc_o,
    input wire logic [15:0]        csw_o,
    input wire logic [35:0]        mac_read_o,
    input wire logic               irq_accept_o,
    input wire logic               clk_halt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wd_q;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // write data of the previous cycle
    always_ff @(posedge clk_sys_i) begin
        wd_q <= wr_data_i;
    end
    // address, space, register, flag, saturation, stop and interrupt checks
    a_fetch_even: assert property (
        asrc_i == crm_pkg::CRM_ASRC_PC |-> !addr_o[0] && space_prog_o)
        else $error("odd or data-space fetch");
    a_data_space: assert property (
        asrc_i inside {[crm_pkg::CRM_ASRC_X:crm_pkg::CRM_ASRC_EXT]}
        |-> !space_prog_o) else $error("data access in program space");
    a_vector_fetch: assert property (
        asrc_i == crm_pkg::CRM_ASRC_VEC |-> addr_o == {4'h0, vec_addr_i}
        && space_prog_o == vec_is_reset_i) else $error("vector fetch wrong");
    a_ext_bank: assert property (
        wr_en_i && wr_sel_i == crm_pkg::CRM_SEL_KREG ##1
        asrc_i == crm_pkg::CRM_ASRC_EXT |-> addr_o[19:16] == wd_q[15:12])
        else $error("extended bank not applied");
    a_dbl_write: assert property (
        wr_en_i && wr_sel_i == crm_pkg::CRM_SEL_DBL |=> dbl_acc_o == wd_q)
        else $error("double accumulator write lost");
    a_mv_set: assert property (
        mac_wr_i && mac_ovf35_i |=> csw_o[crm_pkg::CSW_MV_BIT])
        else $error("mac overflow flag not set");
    a_ev_set: assert property (
        mac_wr_i && mac_ovf31_i |=> csw_o[crm_pkg::CSW_EV_BIT])
        else $error("extension overflow flag not set");
    a_sat_clamp: assert property (
        csw_o[4] && (csw_o[14] || csw_o[12]) |-> mac_read_o ==
        crm_pkg::MAC_SAT_POS || mac_read_o == crm_pkg::MAC_SAT_NEG)
        else $error("saturated read not clamped");
    a_stop_halt: assert property (
        stop_exec_i && !csw_o[15] |=> clk_halt_o[*3])
        else $error("stop did not halt");
    a_stop_nop: assert property (
        stop_exec_i && csw_o[15] && !clk_halt_o |=> !clk_halt_o)
        else $error("stop halted while disabled");
    a_irq_mask: assert property (
        irq_accept_o == (irq_level_i > csw_o[7:5] || irq_level_i == 3'h7))
        else $error("interrupt mask wrong");
    // main scenarios
    c_saturate: cover property (csw_o[4] && csw_o[14]);
    c_halt: cover property (stop_exec_i ##1 clk_halt_o);
    c_reset_vec: cover property (vec_is_reset_i && space_prog_o);
endmodule

bind crm_core crm_core_props crm_core_props_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i),
    .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .asrc_i(asrc_i),
    .vec_addr_i(vec_addr_i), .vec_is_reset_i(vec_is_reset_i),
    .mac_wr_i(mac_wr_i), .mac_ovf35_i(mac_ovf35_i),
    .mac_ovf31_i(mac_ovf31_i), .stop_exec_i(stop_exec_i),
    .irq_level_i(irq_level_i), .addr_o(addr_o), .space_prog_o(space_prog_o),
    .dbl_acc_o(dbl_acc_o), .csw_o(csw_o), .mac_read_o(mac_read_o),
    .irq_accept_o(irq_accept_o), .clk_halt_o(clk_halt_o));

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys_i, resetn_i, req, add, rvv, pcl, push;
    logic                 pull, bop, macw, o35, o31, cmv, cev, stp, vrst;
    logic                 bre, bwe, rd_pend, wr_en, prog, irq_acc, halt;
    logic [2:0]           irq;
    logic [3:0]           bank, baddr, wr_bank, b;
    logic [15:0]          data, opb, ext, vec, bwd, wr_data, bus_rdata;
    logic [15:0]          a, m, d, extra, exp_q[$], msk_q[$];
    logic [16:0]          s;
    logic [19:0]          pcn, addr;
    logic [35:0]          msum;
    logic [7:0]           tbl [9];
    crm_pkg::crm_sel_e    sel, wr_sel;
    crm_pkg::crm_asrc_e   asrc;
    crm_pkg::crm_flags_s  flags;
    crm_pkg::crm_rstvec_s rv;
    int                   n_fail, checked;

    always #4 clk_sys_i = ~clk_sys_i;
    // execution side and the register file
    crm_exec_model crm_exec_model_inst (.clk_sys_i(clk_sys_i), .req_i(req),
        .add_i(add), .sel_i(sel), .data_i(data), .opb_i(opb), .bank_i(bank),
        .wr_sel_o(wr_sel), .wr_en_o(wr_en), .wr_data_o(wr_data),
        .wr_bank_o(wr_bank), .flags_o(flags));
    crm_core crm_core_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .wr_en_i(wr_en), .wr_sel_i(wr_sel), .wr_data_i(wr_data),
        .wr_bank_i(wr_bank), .flags_i(flags), .reset_vec_valid_i(rvv),
        .rst_vec_i(rv), .pc_load_i(pcl), .pc_next_i(pcn), .push_i(push),
        .pull_i(pull), .byte_op_i(bop), .asrc_i(asrc), .ext_addr_i(ext),
        .vec_addr_i(vec), .vec_is_reset_i(vrst), .mac_wr_i(macw),
        .mac_sum_i(msum), .mac_ovf35_i(o35), .mac_ovf31_i(o31),
        .flag_clr_mv_i(cmv), .flag_clr_ev_i(cev), .stop_exec_i(stp),
        .irq_level_i(irq), .bus_addr_i(baddr), .bus_wdata_i(bwd),
        .bus_we_i(bwe), .bus_re_i(bre), .bus_rdata_o(bus_rdata),
        .addr_o(addr), .space_prog_o(prog), .dbl_acc_o(), .extra_acc_o(extra),
        .csw_o(), .mac_read_o(), .irq_accept_o(irq_acc), .clk_halt_o(halt));

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic step;
        bre <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input crm_pkg::crm_sel_e c, input logic [15:0] v,
                      input logic [3:0] k = 4'h0);
        sel <= c;
        data <= v;
        bank <= k;
        req <= 1'b1;
        step();
        req <= 1'b0;
        step();
    endtask
    task automatic rd(input logic [3:0] ad, input logic [15:0] e,
                      input logic [15:0] mk = 16'hFFFF);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        baddr <= ad;
        bre <= 1'b1;
        @(posedge clk_sys_i);
    endtask
    task automatic look(input logic [19:0] e, input int k);
        @(negedge clk_sys_i);
        check(k == 0 ? addr : k == 1 ? prog : k == 2 ? irq_acc : halt, e);
        @(posedge clk_sys_i);
    endtask
    task automatic mac(input logic [35:0] v, input logic f35, f31);
        msum <= v;
        o35 <= f35;
        o31 <= f31;
        macw <= 1'b1;
        step();
        macw <= 1'b0;
    endtask

    // compare each read answer with the oldest note
    always @(posedge clk_sys_i) begin
        if (rd_pend) begin
            m = msk_q.pop_front();
            check(bus_rdata & m, exp_q.pop_front() & m);
        end
        rd_pend <= bre;
    end
    // cut a hung run short
    initial begin
        #100us;
        n_fail++;
        print_verdict();
    end
    // main sequence
    initial begin
        {clk_sys_i, resetn_i, req, add, rvv, pcl, push, pull, bop, macw} = '0;
        {o35, o31, cmv, cev, stp, vrst, bre, bwe, rd_pend, irq, bank} = '0;
        {baddr, data, opb, ext, vec, bwd, pcn, msum, rv, n_fail, checked} = '0;
        sel = crm_pkg::CRM_SEL_NONE;
        asrc = crm_pkg::CRM_ASRC_PC;
        tbl = '{8'h31, 8'h42, 8'h53, 8'h64, 8'h75, 8'hCA, 8'hDB, 8'hEE, 8'hA8};
        void'($urandom(55));
        repeat (8) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rd(4'h7, 16'h00E0, 16'hD0F0);
        d = 16'($urandom);
        wr(crm_pkg::CRM_SEL_DBL, d);
        wr(crm_pkg::CRM_SEL_ACC_HI, 16'h00A5);
        rd(4'h0, {8'hA5, d[7:0]});
        wr(crm_pkg::CRM_SEL_ACC_LO, 16'hFF3C);
        rd(4'h0, 16'hA53C);
        for (int i = 0; i < 9; i++) begin
            d = 16'($urandom);
            b = 4'($urandom);
            wr(crm_pkg::crm_sel_e'(tbl[i][7:4]), d, b);
            rd(tbl[i][3:0], d);
            if (i == 0) check(extra, d);
            if (i > 0 && i < 5) begin
                asrc <= crm_pkg::crm_asrc_e'(i);
                step();
                look({b, d}, 0);
            end
        end
        wr(crm_pkg::CRM_SEL_SK, 16'hFFF9);
        rd(4'h9, 16'h0009, 16'h000F);
        rv <= {1'b1, 4'hC, 16'h1357};
        rvv <= 1'b1;
        asrc <= crm_pkg::CRM_ASRC_Z;
        step();
        rvv <= 1'b0;
        look(20'hC1357, 0);
        wr(crm_pkg::CRM_SEL_SP, 16'h0000, 4'h3);
        asrc <= crm_pkg::CRM_ASRC_SP;
        for (int i = 0; i < 3; i++) begin
            push <= i != 1;
            pull <= i != 0;
            bop <= i == 1;
            step();
            {push, pull} <= 2'b00;
            look(i == 0 ? 20'h2FFFE :
                 i == 1 ? 20'h2FFFF : 20'h2FFFD, 0);
        end
        pcn <= 20'h51235;
        pcl <= 1'b1;
        asrc <= crm_pkg::CRM_ASRC_PC;
        step();
        pcl <= 1'b0;
        look(20'h51234, 0);
        rd(4'h6, 16'h1235);
        rd(4'h7, 16'h0005, 16'h000F);
        asrc <= crm_pkg::CRM_ASRC_EXT;
        wr(crm_pkg::CRM_SEL_KREG, 16'h9876);
        step();
        vec <= 16'h0ABC;
        ext <= 16'h4321;
        for (int i = 0; i < 8; i++) begin
            asrc <= crm_pkg::crm_asrc_e'(i == 7 ? 6 : i);
            vrst <= i == 7;
            step();
            look(i == 0 || i == 7, 1);
            if (i == 5) look(20'h94321, 0);
        end
        add <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = i == 0 ? 16'h7FFF : i == 1 ? 16'hFFFF : 16'($urandom);
            d = i < 2 ? 16'h0001 : 16'($urandom);
            opb <= d;
            s = {1'b0, a} + {1'b0, d};
            wr(crm_pkg::CRM_SEL_DBL, a);
            rd(4'h0, s[15:0]);
            rd(4'h7, {2'h0, s[4] ^ a[4] ^ d[4], 1'b0, s[15],
                s[15:0] == 16'h0, a[15] == d[15] && s[15] != a[15],
                s[16], 8'h00}, 16'h2F00);
        end
        add <= 1'b0;
        bwe <= 1'b1;
        bwd <= 16'hBEEF;
        baddr <= 4'h0;
        step();
        bwe <= 1'b0;
        rd(4'h0, s[15:0]);
        rd(4'hF, 16'h0000);
        wr(crm_pkg::CRM_SEL_CSW, 16'h8070);
        for (int i = 0; i < 8; i++) begin
            irq <= 3'(i);
            step();
            look(i > 3, 2);
        end
        mac(36'h7FFFFFFF0, 1'b0, 1'b0);
        rd(4'hC, 16'h7FFF);
        rd(4'hD, 16'hFFF0);
        mac(36'h800000010, 1'b1, 1'b0);
        rd(4'hC, 16'h7FFF);
        rd(4'hD, 16'hFFFF);
        mac(36'h000000020, 1'b0, 1'b1);
        rd(4'hC, 16'h8000);
        rd(4'h7, 16'h5000, 16'h5000);
        {cmv, cev} <= 2'b11;
        step();
        {cmv, cev} <= 2'b00;
        rd(4'hD, 16'h0020);
        stp <= 1'b1;
        step();
        stp <= 1'b0;
        look(20'h0, 3);
        wr(crm_pkg::CRM_SEL_CSW, 16'h0070);
        stp <= 1'b1;
        step();
        stp <= 1'b0;
        look(20'h1, 3);
        step();
        print_verdict();
    end
endmodule
